// ===== common/idm_pkg.sv
// constants, types and decode functions for the ide bus-master control block
// How it works
// R1: command bit 3 clear means memory reads by the engine, set means memory writes.
// R2: a transfer starts only on a zero-to-one change of the start bit.
// R3: writing start as zero halts any transfer running on that channel.
// R4: simplex bit of the status byte always reads zero.
// R5: drive 1 and drive 0 dma-capable flags are plain read-write storage.
// R6: interrupt flag sets on drive interrupt rising edge, cleared by writing one.
// R7: error flag sets when a memory access of the engine reports an error.
// R8: active sets with start, clears at the last region's end or on stop.
// R9: table pointer is 32 bits, bits 1:0 reserved and read zero.
// R10: sixteen-byte i/o window decoded at the base held in configuration space.
// R11: general control bits 2 and 1 enable secondary and primary channels.
// R12: general control bits 4 and 3 select master pio mode per channel.
// R13: with pin-control enable set, its companion bit sets interrupt pin to 00/01.
// R14: any channel in native mode forces interrupt pin to read 01.
// R15: general control bit 5 holds the internal state machine in reset.
// R16: post-write enable per channel, active high.
// R17: prefetch enable per channel, active high.
// R18: 16-bit prefetch lengths, low then high byte, primary then secondary.
// R19: two configuration bytes give command recovery and active timing.
// R20: recovery code 0 is 12 clocks, 1-11 as is, 12-13 give 13-14, else 15.
// R21: active code 0 is 8 clocks, 1-6 as is, 7 is 12; upper bits zero.
// R22: engine walks descriptors from the table pointer, moving regions until the last.
`default_nettype none
package idm_pkg;
	localparam logic [7:0] CFG_PROG_IF = 8'h09;
	localparam logic [7:0] CFG_BM_BASE0 = 8'h20;
	localparam logic [7:0] CFG_BM_BASE1 = 8'h21;
	localparam logic [7:0] CFG_INT_PIN = 8'h3D;
	localparam logic [7:0] CFG_CMD_REC = 8'h48;
	localparam logic [7:0] CFG_CMD_ACT = 8'h49;
	localparam logic [7:0] CFG_GEN0 = 8'h4A;
	localparam logic [7:0] CFG_GEN1 = 8'h4B;
	localparam logic [7:0] CFG_PF_PRI_LO = 8'h4C;
	localparam logic [7:0] CFG_PF_PRI_HI = 8'h4D;
	localparam logic [7:0] CFG_PF_SEC_LO = 8'h4E;
	localparam logic [7:0] CFG_PF_SEC_HI = 8'h4F;
	localparam logic [7:0] PROG_IF_FIXED = 8'h8A;
	localparam logic [3:0] BM_BASE_IO_FLAG = 4'h1;
	localparam logic [7:0] GEN0_WMASK = 8'h1E;
	localparam logic [7:0] GEN1_WMASK = 8'hEF;
	localparam int GEN0_PRI_EN = 1;
	localparam int GEN0_PRI_PIO = 3;
	localparam int GEN1_PRI_PF = 0;
	localparam int GEN1_PRI_PW = 2;
	localparam int GEN1_SMRST = 5;
	localparam int GEN1_PIN_EN = 6;
	localparam int GEN1_PIN_VAL = 7;
	localparam logic [2:0] IO_CMD = 3'h0;
	localparam logic [2:0] IO_STATUS = 3'h2;
	localparam logic [2:0] IO_PTR0 = 3'h4;
	localparam logic [2:0] IO_PTR1 = 3'h5;
	localparam logic [2:0] IO_PTR2 = 3'h6;
	localparam logic [2:0] IO_PTR3 = 3'h7;
	localparam int CMD_START = 0;
	localparam int CMD_DIR = 3;
	localparam int ST_ERR = 1;
	localparam int ST_IRQ = 2;
	localparam int ST_DRV0 = 5;
	localparam int ST_DRV1 = 6;
	localparam logic [7:0] INT_PIN_NATIVE = 8'h01;
	localparam logic [14:0] REGION_MAX_WORDS = 15'h4000;
	localparam int DESC_EOT = 31;
	localparam logic [7:0] REC_RST = 8'h00;
	localparam logic [7:0] ACT_RST = 8'h00;
	localparam logic [7:0] GEN0_RST = 8'h00;
	localparam logic [7:0] GEN1_RST = 8'h00;
	localparam logic [15:0] PF_LEN_RST = 16'h0000;
	localparam logic [3:0] REC_CLKS_CODE0 = 4'hC;
	localparam logic [3:0] REC_CLKS_MAX = 4'hF;
	localparam logic [3:0] ACT_CLKS_CODE0 = 4'h8;
	localparam logic [3:0] ACT_CLKS_CODE7 = 4'hC;

	typedef enum logic [2:0] {ST_IDLE, ST_DESC_ADDR, ST_DESC_CNT, ST_MOVE, ST_WAIT_TX} idm_fsm_t;

	function automatic logic [3:0] rec_clks(input logic [3:0] code);
		if (code == 4'h0) begin
			return REC_CLKS_CODE0;
		end else if (code <= 4'hB) begin
			return code;
		end else if (code <= 4'hD) begin
			return code + 4'h1;
		end
		return REC_CLKS_MAX;
	endfunction

	function automatic logic [3:0] act_clks(input logic [2:0] code);
		if (code == 3'h0) begin
			return ACT_CLKS_CODE0;
		end else if (code == 3'h7) begin
			return ACT_CLKS_CODE7;
		end
		return {1'b0, code};
	endfunction
endpackage
`default_nettype wire

// ===== core/idm_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module idm_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta_q;
		logic [WIDTH-1:0] sync_q;
	} idm_sync_st_t;

	idm_sync_st_t s_q;
	idm_sync_st_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta_q = d;
		s_d.sync_q = s_q.meta_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.sync_q;
endmodule
`default_nettype wire

// ===== core/idm_arb.sv
// memory port arbiter: an owner keeps the port while it requests
`timescale 1ns/10ps
`default_nettype none
module idm_arb (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [1:0] req,
	output logic      [1:0] gnt
);
	typedef struct packed {
		logic owner_q;
	} idm_arb_st_t;

	idm_arb_st_t s_q;
	idm_arb_st_t s_d;

	always_comb begin
		s_d = s_q;
		gnt = 2'h0;
		if (req[s_q.owner_q]) begin
			gnt[s_q.owner_q] = 1'b1;
		end else if (req[!s_q.owner_q]) begin
			gnt[!s_q.owner_q] = 1'b1;
			s_d.owner_q = !s_q.owner_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ===== core/idm_top.sv
// ide bus-master control: configuration bytes, i/o window and two descriptor engines
`timescale 1ns/10ps
`default_nettype none
module idm_top (
	input  wire logic             SYS_CLK,
	input  wire logic             RST_B,
	input  wire logic             CFG_WR,
	input  wire logic             CFG_RD,
	input  wire logic [7:0]       CFG_ADDR,
	input  wire logic [7:0]       CFG_WDATA,
	output logic      [7:0]       CFG_RDATA,
	input  wire logic             IO_WR,
	input  wire logic             IO_RD,
	input  wire logic [15:0]      IO_ADDR,
	input  wire logic [7:0]       IO_WDATA,
	output logic      [7:0]       IO_RDATA,
	output logic                  IO_HIT,
	output logic                  MEM_REQ,
	output logic                  MEM_WE,
	output logic      [31:0]      MEM_ADDR,
	output logic      [31:0]      MEM_WDATA,
	input  wire logic             MEM_ACK,
	input  wire logic             MEM_ERR,
	input  wire logic [31:0]      MEM_RDATA,
	input  wire logic [1:0]       DRIVE_IRQ,
	input  wire logic [1:0]       RX_VALID,
	input  wire logic [1:0][31:0] RX_DATA,
	output logic      [1:0]       RX_READY,
	output logic      [1:0]       TX_VALID,
	output logic      [1:0][31:0] TX_DATA,
	input  wire logic [1:0]       TX_READY,
	output logic      [1:0]       CHAN_ENABLE,
	output logic      [1:0]       MASTER_PIO,
	output logic      [1:0]       POST_WRITE_EN,
	output logic      [1:0]       PREFETCH_EN,
	output logic      [1:0][15:0] PREFETCH_LEN,
	output logic      [1:0]       NATIVE_MODE,
	output logic      [7:0]       INT_PIN,
	output logic                  IDE_SM_RESET,
	output logic      [3:0]       CMD_RECOVERY_CLKS,
	output logic      [3:0]       CMD_ACTIVE_CLKS,
	output logic      [1:0]       XFER_ACTIVE,
	output logic      [1:0]       XFER_DIR
);
	typedef struct packed {
		logic [3:0]                  rec;
		logic [2:0]                  act;
		logic [7:0]                  gen0;
		logic [7:0]                  gen1;
		logic [1:0][15:0]            pf_len;
		logic [1:0]                  native;
		logic                        int_pin;
		logic [11:0]                 bm_base;
		logic [7:0]                  cfg_rdata;
		logic [7:0]                  io_rdata;
		logic                        io_hit;
		logic [1:0]                  dir;
		logic [1:0]                  start;
		logic [1:0]                  drv1_dma;
		logic [1:0]                  drv0_dma;
		logic [1:0]                  irq_flag;
		logic [1:0]                  err_flag;
		logic [1:0]                  active;
		logic [1:0]                  irq_prev;
		logic [1:0][29:0]            tbl_ptr;
		logic [1:0][29:0]            desc_ptr;
		logic [1:0][29:0]            rgn_addr;
		logic [1:0][29:0]            mem_addr;
		logic [1:0]                  req;
		logic [1:0]                  we;
		logic [1:0][31:0]            wdata;
		logic [1:0][31:0]            tx_data;
		logic [1:0]                  tx_valid;
		logic [1:0][14:0]            words;
		logic [1:0]                  eot;
		idm_pkg::idm_fsm_t [1:0]     fsm;
	} idm_state_t;

	idm_state_t s_q;
	idm_state_t s_d;
	logic [1:0] irq_sync;
	logic [1:0] gnt;
	logic       io_hit;
	logic       io_ch;
	logic [7:0] int_pin_rd;

	idm_sync #(
		.WIDTH (2)
	) u_irq_sync (
		.clk   (SYS_CLK),
		.rst_b (RST_B),
		.d     (DRIVE_IRQ),
		.q     (irq_sync)
	);

	// only one engine owns the memory port at a time
	idm_arb u_arb (
		.clk   (SYS_CLK),
		.rst_b (RST_B),
		.req   (s_q.req),
		.gnt   (gnt)
	);

	assign io_hit = (IO_ADDR[15:4] == s_q.bm_base); // [R10]
	assign io_ch = IO_ADDR[3];
	// native mode on either channel overrides the pin-control bits
	assign int_pin_rd = (s_q.native != 2'h0) ? idm_pkg::INT_PIN_NATIVE : {7'h00, s_q.int_pin}; // [R14]

	always_comb begin
		logic ack;
		logic err;
		logic wr_here;
		logic done;
		ack = 1'b0;
		err = 1'b0;
		wr_here = 1'b0;
		done = 1'b0;
		s_d = s_q;
		s_d.io_hit = 1'b0;

		if (CFG_WR) begin
			case (CFG_ADDR)
				idm_pkg::CFG_PROG_IF: begin
					s_d.native = {CFG_WDATA[2], CFG_WDATA[0]};
				end
				idm_pkg::CFG_BM_BASE0: begin
					s_d.bm_base[3:0] = CFG_WDATA[7:4]; // [R10]
				end
				idm_pkg::CFG_BM_BASE1: begin
					s_d.bm_base[11:4] = CFG_WDATA; // [R10]
				end
				idm_pkg::CFG_CMD_REC: begin
					s_d.rec = CFG_WDATA[3:0]; // [R19] [R20]
				end
				idm_pkg::CFG_CMD_ACT: begin
					s_d.act = CFG_WDATA[2:0]; // [R19] [R21]
				end
				idm_pkg::CFG_GEN0: begin
					s_d.gen0 = CFG_WDATA & idm_pkg::GEN0_WMASK; // [R11] [R12]
				end
				idm_pkg::CFG_GEN1: begin
					s_d.gen1 = CFG_WDATA & idm_pkg::GEN1_WMASK; // [R15] [R16] [R17]
					if (CFG_WDATA[idm_pkg::GEN1_PIN_EN]) begin
						s_d.int_pin = CFG_WDATA[idm_pkg::GEN1_PIN_VAL]; // [R13]
					end
				end
				idm_pkg::CFG_PF_PRI_LO: begin
					s_d.pf_len[0][7:0] = CFG_WDATA; // [R18]
				end
				idm_pkg::CFG_PF_PRI_HI: begin
					s_d.pf_len[0][15:8] = CFG_WDATA; // [R18]
				end
				idm_pkg::CFG_PF_SEC_LO: begin
					s_d.pf_len[1][7:0] = CFG_WDATA; // [R18]
				end
				idm_pkg::CFG_PF_SEC_HI: begin
					s_d.pf_len[1][15:8] = CFG_WDATA; // [R18]
				end
				default: begin
				end
			endcase
		end

		if (CFG_RD) begin
			case (CFG_ADDR)
				idm_pkg::CFG_PROG_IF: begin
					s_d.cfg_rdata = idm_pkg::PROG_IF_FIXED | {5'h00, s_q.native[1], 1'b0, s_q.native[0]};
				end
				idm_pkg::CFG_BM_BASE0: begin
					s_d.cfg_rdata = {s_q.bm_base[3:0], idm_pkg::BM_BASE_IO_FLAG};
				end
				idm_pkg::CFG_BM_BASE1: begin
					s_d.cfg_rdata = s_q.bm_base[11:4];
				end
				idm_pkg::CFG_INT_PIN: begin
					s_d.cfg_rdata = int_pin_rd; // [R13] [R14]
				end
				idm_pkg::CFG_CMD_REC: begin
					s_d.cfg_rdata = {4'h0, s_q.rec}; // [R20]
				end
				idm_pkg::CFG_CMD_ACT: begin
					s_d.cfg_rdata = {5'h00, s_q.act}; // [R21]
				end
				idm_pkg::CFG_GEN0: begin
					s_d.cfg_rdata = s_q.gen0;
				end
				idm_pkg::CFG_GEN1: begin
					s_d.cfg_rdata = s_q.gen1;
				end
				idm_pkg::CFG_PF_PRI_LO: begin
					s_d.cfg_rdata = s_q.pf_len[0][7:0];
				end
				idm_pkg::CFG_PF_PRI_HI: begin
					s_d.cfg_rdata = s_q.pf_len[0][15:8];
				end
				idm_pkg::CFG_PF_SEC_LO: begin
					s_d.cfg_rdata = s_q.pf_len[1][7:0];
				end
				idm_pkg::CFG_PF_SEC_HI: begin
					s_d.cfg_rdata = s_q.pf_len[1][15:8];
				end
				default: begin
					s_d.cfg_rdata = 8'h00;
				end
			endcase
		end

		if (IO_RD && io_hit) begin
			s_d.io_hit = 1'b1;
			case (IO_ADDR[2:0])
				idm_pkg::IO_CMD: begin
					s_d.io_rdata = {4'h0, s_q.dir[io_ch], 2'h0, s_q.start[io_ch]};
				end
				idm_pkg::IO_STATUS: begin
					// simplex bit stays zero
					s_d.io_rdata = {1'b0, s_q.drv1_dma[io_ch], s_q.drv0_dma[io_ch], 2'h0,
						s_q.irq_flag[io_ch], s_q.err_flag[io_ch], s_q.active[io_ch]}; // [R4]
				end
				idm_pkg::IO_PTR0: begin
					s_d.io_rdata = {s_q.tbl_ptr[io_ch][5:0], 2'h0}; // [R9]
				end
				idm_pkg::IO_PTR1: begin
					s_d.io_rdata = s_q.tbl_ptr[io_ch][13:6];
				end
				idm_pkg::IO_PTR2: begin
					s_d.io_rdata = s_q.tbl_ptr[io_ch][21:14];
				end
				idm_pkg::IO_PTR3: begin
					s_d.io_rdata = s_q.tbl_ptr[io_ch][29:22];
				end
				default: begin
					s_d.io_rdata = 8'h00;
				end
			endcase
		end

		for (int c = 0; c < 2; c++) begin
			ack = MEM_ACK & gnt[c] & s_q.req[c];
			err = MEM_ERR & gnt[c] & s_q.req[c];
			wr_here = IO_WR & io_hit & (io_ch == 1'(c));
			done = 1'b0;
			s_d.irq_prev[c] = irq_sync[c];

			case (s_q.fsm[c])
				idm_pkg::ST_DESC_ADDR: begin
					if (ack) begin
						s_d.rgn_addr[c] = MEM_RDATA[31:2]; // [R22]
						s_d.desc_ptr[c] = s_q.desc_ptr[c] + 30'h1;
						s_d.mem_addr[c] = s_q.desc_ptr[c] + 30'h1;
						s_d.fsm[c] = idm_pkg::ST_DESC_CNT;
					end
				end
				idm_pkg::ST_DESC_CNT: begin
					if (ack) begin
						s_d.words[c] = (MEM_RDATA[15:2] == 14'h0) ? idm_pkg::REGION_MAX_WORDS
							: {1'b0, MEM_RDATA[15:2]}; // [R22]
						s_d.eot[c] = MEM_RDATA[idm_pkg::DESC_EOT];
						s_d.desc_ptr[c] = s_q.desc_ptr[c] + 30'h1;
						s_d.mem_addr[c] = s_q.rgn_addr[c];
						s_d.req[c] = !s_q.dir[c];
						s_d.we[c] = s_q.dir[c]; // [R1]
						s_d.fsm[c] = idm_pkg::ST_MOVE;
					end
				end
				idm_pkg::ST_MOVE: begin
					if (s_q.dir[c]) begin
						// drive data is written to memory
						if (!s_q.req[c] && RX_VALID[c]) begin
							s_d.wdata[c] = RX_DATA[c]; // [R1]
							s_d.req[c] = 1'b1;
						end else if (ack) begin
							s_d.req[c] = 1'b0;
							done = 1'b1;
						end
					end else if (ack) begin
						s_d.tx_data[c] = MEM_RDATA; // [R1]
						s_d.tx_valid[c] = 1'b1;
						s_d.req[c] = 1'b0;
						s_d.fsm[c] = idm_pkg::ST_WAIT_TX;
					end
				end
				idm_pkg::ST_WAIT_TX: begin
					if (TX_READY[c]) begin
						s_d.tx_valid[c] = 1'b0;
						done = 1'b1;
					end
				end
				default: begin
				end
			endcase

			if (done) begin
				s_d.mem_addr[c] = s_q.mem_addr[c] + 30'h1;
				s_d.words[c] = s_q.words[c] - 15'h1;
				s_d.fsm[c] = idm_pkg::ST_MOVE;
				s_d.req[c] = !s_q.dir[c];
				if (s_q.words[c] == 15'h1) begin
					if (s_q.eot[c]) begin
						s_d.fsm[c] = idm_pkg::ST_IDLE; // [R22]
						s_d.req[c] = 1'b0;
						s_d.active[c] = 1'b0; // [R8]
					end else begin
						s_d.fsm[c] = idm_pkg::ST_DESC_ADDR; // [R22]
						s_d.mem_addr[c] = s_q.desc_ptr[c];
						s_d.req[c] = 1'b1;
						s_d.we[c] = 1'b0;
					end
				end
			end

			if (wr_here) begin
				case (IO_ADDR[2:0])
					idm_pkg::IO_CMD: begin
						s_d.dir[c] = IO_WDATA[idm_pkg::CMD_DIR]; // [R1]
						s_d.start[c] = IO_WDATA[idm_pkg::CMD_START];
						if (IO_WDATA[idm_pkg::CMD_START] && !s_q.start[c]
							&& s_q.gen0[idm_pkg::GEN0_PRI_EN + c]) begin
							// only a rising start bit on an enabled channel launches
							s_d.active[c] = 1'b1; // [R2] [R8] [R11]
							s_d.fsm[c] = idm_pkg::ST_DESC_ADDR; // [R22]
							s_d.desc_ptr[c] = s_q.tbl_ptr[c];
							s_d.mem_addr[c] = s_q.tbl_ptr[c];
							s_d.req[c] = 1'b1;
							s_d.we[c] = 1'b0;
							s_d.tx_valid[c] = 1'b0;
						end else if (!IO_WDATA[idm_pkg::CMD_START]) begin
							s_d.active[c] = 1'b0; // [R3] [R8]
							s_d.fsm[c] = idm_pkg::ST_IDLE; // [R3]
							s_d.req[c] = 1'b0;
							s_d.tx_valid[c] = 1'b0;
						end
					end
					idm_pkg::IO_STATUS: begin
						s_d.drv1_dma[c] = IO_WDATA[idm_pkg::ST_DRV1]; // [R5]
						s_d.drv0_dma[c] = IO_WDATA[idm_pkg::ST_DRV0]; // [R5]
						if (IO_WDATA[idm_pkg::ST_IRQ]) begin
							s_d.irq_flag[c] = 1'b0; // [R6]
						end
						if (IO_WDATA[idm_pkg::ST_ERR]) begin
							s_d.err_flag[c] = 1'b0;
						end
					end
					idm_pkg::IO_PTR0: begin
						s_d.tbl_ptr[c][5:0] = IO_WDATA[7:2]; // [R9]
					end
					idm_pkg::IO_PTR1: begin
						s_d.tbl_ptr[c][13:6] = IO_WDATA;
					end
					idm_pkg::IO_PTR2: begin
						s_d.tbl_ptr[c][21:14] = IO_WDATA;
					end
					idm_pkg::IO_PTR3: begin
						s_d.tbl_ptr[c][29:22] = IO_WDATA;
					end
					default: begin
					end
				endcase
			end

			// hardware sets win over a same-cycle software clear
			if (irq_sync[c] && !s_q.irq_prev[c]) begin
				s_d.irq_flag[c] = 1'b1; // [R6]
			end
			if (err) begin
				s_d.err_flag[c] = 1'b1; // [R7]
				s_d.active[c] = 1'b0;
				s_d.fsm[c] = idm_pkg::ST_IDLE;
				s_d.req[c] = 1'b0;
				s_d.tx_valid[c] = 1'b0;
			end
			if (s_q.gen1[idm_pkg::GEN1_SMRST]) begin
				s_d.fsm[c] = idm_pkg::ST_IDLE; // [R15]
				s_d.req[c] = 1'b0;
				s_d.tx_valid[c] = 1'b0;
				s_d.active[c] = 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			s_q <= '0;
			s_q.rec <= idm_pkg::REC_RST[3:0];
			s_q.act <= idm_pkg::ACT_RST[2:0];
			s_q.gen0 <= idm_pkg::GEN0_RST;
			s_q.gen1 <= idm_pkg::GEN1_RST;
			s_q.pf_len <= {idm_pkg::PF_LEN_RST, idm_pkg::PF_LEN_RST};
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			RX_READY[c] = (s_q.fsm[c] == idm_pkg::ST_MOVE) && s_q.dir[c] && !s_q.req[c];
			CHAN_ENABLE[c] = s_q.gen0[idm_pkg::GEN0_PRI_EN + c]; // [R11]
			MASTER_PIO[c] = s_q.gen0[idm_pkg::GEN0_PRI_PIO + c]; // [R12]
			POST_WRITE_EN[c] = s_q.gen1[idm_pkg::GEN1_PRI_PW + c]; // [R16]
			PREFETCH_EN[c] = s_q.gen1[idm_pkg::GEN1_PRI_PF + c]; // [R17]
		end
	end

	assign MEM_REQ = |(s_q.req & gnt);
	assign MEM_WE = s_q.we[gnt[1]];
	assign MEM_ADDR = {s_q.mem_addr[gnt[1]], 2'h0};
	assign MEM_WDATA = s_q.wdata[gnt[1]];
	assign TX_VALID = s_q.tx_valid;
	assign TX_DATA = s_q.tx_data;
	assign PREFETCH_LEN = s_q.pf_len; // [R18]
	assign NATIVE_MODE = s_q.native;
	assign INT_PIN = int_pin_rd;
	assign IDE_SM_RESET = s_q.gen1[idm_pkg::GEN1_SMRST];
	assign CMD_RECOVERY_CLKS = idm_pkg::rec_clks(s_q.rec); // [R20]
	assign CMD_ACTIVE_CLKS = idm_pkg::act_clks(s_q.act); // [R21]
	assign XFER_ACTIVE = s_q.active;
	assign XFER_DIR = s_q.dir;
	assign CFG_RDATA = s_q.cfg_rdata;
	assign IO_RDATA = s_q.io_rdata;
	assign IO_HIT = s_q.io_hit;
endmodule
`default_nettype wire

// ===== verif/idm_mem_model.sv
// far-side model: memory responder and drive data streams
`timescale 1ns/10ps
`default_nettype none
module idm_mem_model (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             slow,
	input  wire logic             fail,
	input  wire logic             mem_req,
	input  wire logic             mem_we,
	input  wire logic [31:0]      mem_addr,
	input  wire logic [31:0]      mem_wdata,
	output logic                  mem_ack,
	output logic                  mem_err,
	output logic      [31:0]      mem_rdata,
	input  wire logic [1:0]       rx_ready,
	output logic      [1:0][31:0] rx_data,
	output logic      [1:0]       tx_ready
);
	logic [31:0] mem [0:63];
	logic [1:0]  cnt;
	logic        ack_q;
	logic        tog;
	logic [31:0] rx_q;
	// read data is garbage outside the answering cycle
	assign mem_rdata = ack_q ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
	assign mem_ack = ack_q & ~fail;
	assign mem_err = ack_q & fail;
	assign rx_data = {rx_q, rx_q};
	assign tx_ready = slow ? {tog, tog} : 2'h3;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'h0;
			cnt <= 2'h0;
			tog <= 1'h0;
			rx_q <= 32'hC0DE0000;
		end else begin
			tog <= ~tog;
			ack_q <= 1'h0;
			if (rx_ready[0])
				rx_q <= rx_q + 32'h1;
			if (mem_req && !ack_q) begin
				cnt <= cnt + 2'h1;
				if (!slow || cnt == 2'h2) begin
					ack_q <= 1'h1;
					cnt <= 2'h0;
					if (mem_we && !fail)
						mem[mem_addr[7:2]] <= mem_wdata;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/idm_top_monitor.sv
// checker on the top-level ports of the ide bus-master block
`timescale 1ns/10ps
`default_nettype none
module idm_top_monitor (
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	input wire logic        CFG_WR,
	input wire logic [7:0]  CFG_ADDR,
	input wire logic [7:0]  CFG_WDATA,
	input wire logic [15:0] IO_ADDR,
	input wire logic [7:0]  IO_RDATA,
	input wire logic        IO_HIT,
	input wire logic        IO_RD,
	input wire logic        MEM_REQ,
	input wire logic        MEM_WE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic        MEM_ACK,
	input wire logic        MEM_ERR,
	input wire logic [1:0]  NATIVE_MODE,
	input wire logic [7:0]  INT_PIN,
	input wire logic [1:0]  CHAN_ENABLE,
	input wire logic [3:0]  CMD_RECOVERY_CLKS,
	input wire logic [3:0]  CMD_ACTIVE_CLKS,
	input wire logic [1:0]  XFER_ACTIVE,
	input wire logic [1:0]  XFER_DIR
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	logic [3:0] wd;
	logic [3:0] rec_e;
	logic [3:0] act_e;
	assign wd = CFG_WDATA[3:0];
	assign rec_e = wd == 4'h0 ? 4'hC : wd < 4'hC ? wd : wd < 4'hE ? wd + 4'h1 : 4'hF;
	assign act_e = wd[2:0] == 3'h0 ? 4'h8 : wd[2:0] == 3'h7 ? 4'hC : {1'h0, wd[2:0]};
	chk_simplex_zero: assert property (IO_HIT && $past(IO_ADDR[2:0]) == 3'h2
		|-> IO_RDATA[7] == 1'h0) else $error("simplex bit set");
	chk_ptr_low_zero: assert property (IO_HIT && $past(IO_ADDR[2:0]) == 3'h4
		|-> IO_RDATA[1:0] == 2'h0) else $error("pointer low bits set");
	chk_hit_after_read: assert property (IO_HIT |-> $past(IO_RD))
		else $error("hit without read");
	chk_rec_decode: assert property (CFG_WR && CFG_ADDR == 8'h48
		|=> CMD_RECOVERY_CLKS == $past(rec_e)) else $error("recovery decode");
	chk_act_decode: assert property (CFG_WR && CFG_ADDR == 8'h49
		|=> CMD_ACTIVE_CLKS == $past(act_e)) else $error("active decode");
	chk_native_pin: assert property (NATIVE_MODE != 2'h0 |-> INT_PIN == 8'h01)
		else $error("native pin value");
	chk_pin_control: assert property (CFG_WR && CFG_ADDR == 8'h4B && CFG_WDATA[6] &&
		NATIVE_MODE == 2'h0 |=> INT_PIN == {7'h0, $past(CFG_WDATA[7])}) else $error("pin control");
	chk_chan_enable: assert property (CFG_WR && CFG_ADDR == 8'h4A
		|=> CHAN_ENABLE == $past(CFG_WDATA[2:1])) else $error("channel enable");
	chk_req_active: assert property (MEM_REQ |-> XFER_ACTIVE != 2'h0)
		else $error("request while idle");
	chk_dir_write: assert property (MEM_REQ && MEM_WE && XFER_ACTIVE == 2'h1
		|-> XFER_DIR[0]) else $error("write against direction");
	chk_req_steady: assert property (MEM_REQ && !MEM_ACK && !MEM_ERR
		|=> !MEM_REQ || $stable(MEM_ADDR) && $stable(MEM_WE)) else $error("request moved");
	cov_mem_err: cover property (MEM_REQ && MEM_ERR);
	cov_mem_wr: cover property (MEM_REQ && MEM_WE && MEM_ACK);
	cov_io_hit: cover property (IO_HIT);
endmodule
bind idm_top idm_top_monitor mon_u (.*);
`default_nettype wire

// ===== verif/ide_bus_master_control_tb_top.sv
// self-checking bench for the ide bus-master control block
`timescale 1ns/10ps
`default_nettype none
module ide_bus_master_control_tb_top;
	localparam logic [15:0] B = 16'h1240;
	logic SYS_CLK, RST_B, CFG_WR, CFG_RD, IO_WR, IO_RD, slow, fail, hit;
	logic [7:0] CFG_ADDR, CFG_WDATA, CFG_RDATA, IO_WDATA, IO_RDATA, INT_PIN, rd;
	logic [15:0] IO_ADDR;
	logic IO_HIT, MEM_REQ, MEM_WE, MEM_ACK, MEM_ERR, IDE_SM_RESET;
	logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA;
	logic [1:0] DRIVE_IRQ, RX_VALID, RX_READY, TX_VALID, TX_READY, CHAN_ENABLE, MASTER_PIO;
	logic [1:0] POST_WRITE_EN, PREFETCH_EN, NATIVE_MODE, XFER_ACTIVE, XFER_DIR;
	logic [1:0][31:0] RX_DATA, TX_DATA;
	logic [1:0][15:0] PREFETCH_LEN;
	logic [3:0] CMD_RECOVERY_CLKS, CMD_ACTIVE_CLKS;
	logic [31:0] txq[$];
	int bad_count, compares, i;
	idm_top dut_u (.*);
	idm_mem_model mem_u (.clk(SYS_CLK), .rst_b(RST_B), .slow(slow), .fail(fail),
		.mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
		.mem_ack(MEM_ACK), .mem_err(MEM_ERR), .mem_rdata(MEM_RDATA), .rx_ready(RX_READY),
		.rx_data(RX_DATA), .tx_ready(TX_READY));
	always #50 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK) if (TX_VALID[0] && TX_READY[0]) txq.push_back(TX_DATA[0]);
	task automatic ck(input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		if (io) begin
			IO_ADDR <= a;
			IO_WDATA <= d;
			IO_WR <= wr;
			IO_RD <= ~wr;
		end else begin
			CFG_ADDR <= a[7:0];
			CFG_WDATA <= d;
			CFG_WR <= wr;
			CFG_RD <= ~wr;
		end
		@(posedge SYS_CLK);
		{CFG_WR, CFG_RD, IO_WR, IO_RD} <= 4'h0;
		#1;
		rd = io ? IO_RDATA : CFG_RDATA;
		hit = IO_HIT;
	endtask
	task automatic w(input logic io, input logic [15:0] a, input logic [7:0] d);
		acc(io, 1'h1, a, d);
	endtask
	task automatic rc(input logic io, input logic [15:0] a, input logic [7:0] e);
		acc(io, 1'h0, a, 8'h00);
		ck(rd, e);
	endtask
	task automatic go(input logic [7:0] p, input logic [7:0] c);
		for (int j = 0; j < 4; j++) w(1'h1, B + 16'h4 + j, j == 0 ? p : 8'h00);
		w(1'h1, B, c);
	endtask
	task automatic idle();
		for (int n = 0; n < 500 && XFER_ACTIVE[0] !== 1'h0; n++) @(posedge SYS_CLK);
		#1;
		ck(XFER_ACTIVE[0], 0);
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		SYS_CLK = 1'h0;
		RST_B = 1'h0;
		{CFG_WR, CFG_RD, IO_WR, IO_RD, slow, fail} = 6'h0;
		{CFG_ADDR, CFG_WDATA, IO_WDATA, IO_ADDR, DRIVE_IRQ} = 42'h0;
		RX_VALID = 2'h3;
		repeat (8) @(posedge SYS_CLK);
		RST_B <= 1'h1;
		#1;
		ck({CMD_RECOVERY_CLKS, CMD_ACTIVE_CLKS}, 8'hC8);
		for (i = 8'h48; i < 8'h50; i++) rc(1'h0, i, 8'h00);
		for (i = 0; i < 16; i++) begin
			w(1'h0, 16'h48, 8'hF0 | i);
			ck(CMD_RECOVERY_CLKS, i == 0 ? 12 : i < 12 ? i : i < 14 ? i + 1 : 15);
			rc(1'h0, 16'h48, i);
		end
		for (i = 0; i < 8; i++) begin
			w(1'h0, 16'h49, 8'hF8 | i);
			ck(CMD_ACTIVE_CLKS, i == 0 ? 8 : i == 7 ? 12 : i);
			rc(1'h0, 16'h49, i);
		end
		w(1'h0, 16'h4A, 8'hFF);
		rc(1'h0, 16'h4A, 8'h1E);
		ck({CHAN_ENABLE, MASTER_PIO}, 4'hF);
		w(1'h0, 16'h4B, 8'h2F);
		ck({IDE_SM_RESET, POST_WRITE_EN, PREFETCH_EN}, 5'h1F);
		w(1'h0, 16'h4B, 8'hC0);
		ck({IDE_SM_RESET, INT_PIN}, 9'h001);
		w(1'h0, 16'h4B, 8'h40);
		ck(INT_PIN, 8'h00);
		w(1'h0, 16'h4B, 8'h80);
		ck(INT_PIN, 8'h00);
		for (i = 1; i < 5; i += 3) begin
			w(1'h0, 16'h09, i);
			rc(1'h0, 16'h3D, 8'h01);
		end
		w(1'h0, 16'h09, 8'h00);
		for (i = 0; i < 4; i++) w(1'h0, 16'h4C + i, 8'h11 * (i + 1));
		ck({PREFETCH_LEN[1], PREFETCH_LEN[0]}, 32'h44332211);
		w(1'h0, 16'h20, 8'h40);
		w(1'h0, 16'h21, 8'h12);
		acc(1'h1, 1'h0, 16'h2002, 8'h00);
		ck(hit, 0);
		w(1'h1, B + 16'h2, 8'hFF);
		rc(1'h1, B + 16'h2, 8'h60);
		rc(1'h1, B + 16'h1, 8'h00);
		w(1'h1, B + 16'h4, 8'hFF);
		rc(1'h1, B + 16'h4, 8'hFC);
		mem_u.mem[4] = 32'h40;
		mem_u.mem[5] = 32'h80000008;
		mem_u.mem[6] = 32'h60;
		mem_u.mem[7] = 32'h80000008;
		mem_u.mem[8] = 32'h40;
		mem_u.mem[9] = 32'h80000100;
		mem_u.mem[16] = 32'hA5A50001;
		mem_u.mem[17] = 32'h5A5A0002;
		@(posedge SYS_CLK) slow <= 1'h1;
		go(8'h10, 8'h01);
		idle();
		ck(txq.size(), 2);
		ck({txq[0], txq[1]}, 64'hA5A500015A5A0002);
		rc(1'h1, B + 16'h2, 8'h60);
		@(posedge SYS_CLK) DRIVE_IRQ <= 2'h1;
		repeat (4) @(posedge SYS_CLK);
		rc(1'h1, B + 16'h2, 8'h64);
		w(1'h1, B + 16'h2, 8'h64);
		rc(1'h1, B + 16'h2, 8'h60);
		w(1'h1, B, 8'h08);
		go(8'h18, 8'h09);
		ck(XFER_DIR[0], 1);
		idle();
		ck({mem_u.mem[24], mem_u.mem[25]}, 64'hC0DE0000C0DE0001);
		w(1'h1, B, 8'h09);
		ck({XFER_ACTIVE[0], MEM_REQ}, 0);
		w(1'h1, B, 8'h00);
		go(8'h20, 8'h01);
		repeat (10) @(posedge SYS_CLK);
		ck(XFER_ACTIVE[0], 1);
		w(1'h1, B, 8'h00);
		ck({XFER_ACTIVE[0], MEM_REQ}, 0);
		@(posedge SYS_CLK) fail <= 1'h1;
		go(8'h10, 8'h01);
		idle();
		rc(1'h1, B + 16'h2, 8'h62);
		@(posedge SYS_CLK) fail <= 1'h0;
		w(1'h1, B + 16'h2, 8'h62);
		rc(1'h1, B + 16'h2, 8'h60);
		w(1'h0, 16'h4A, 8'h02);
		w(1'h1, B + 16'h8, 8'h01);
		ck({CHAN_ENABLE, XFER_ACTIVE[1]}, 3'h2);
		w(1'h1, B, 8'h00);
		go(8'h20, 8'h01);
		w(1'h0, 16'h4B, 8'h20);
		@(posedge SYS_CLK) #1;
		ck({IDE_SM_RESET, XFER_ACTIVE[0]}, 2'h2);
		give_verdict();
	end
	initial begin
		#3000000;
		bad_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
